/* pkg/gwr_pkg.sv */
`default_nettype none
package gwr_pkg;
   localparam int          DATA_BITS     = 32;
   localparam int          ADDR_BITS     = 4;
   localparam int          OP_BITS       = 2;
   localparam int          FRAME_BITS    = OP_BITS + DATA_BITS + ADDR_BITS;
   localparam int          NUM_BLOCKS    = 10;
   localparam logic [1:0]  WRITE_OPCODE  = 2'h2;
   localparam logic [5:0]  ZERO_MIN      = 6'h10;
   localparam logic [5:0]  ZERO_MAX      = 6'h1f;
   localparam logic [5:0]  ONE_MIN       = 6'h30;
   localparam logic [5:0]  ONE_MAX       = 6'h3f;
   localparam logic [6:0]  CNT_SAT       = 7'h40;
   localparam logic [5:0]  FRAME_CNT_W   = 6'h26;

   typedef enum logic [1:0] {
      GWR_READ  = 2'b00,
      GWR_START = 2'b01,
      GWR_RECV  = 2'b11
   } gwr_state_t;

   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;
      logic [DATA_BITS-1:0] data;
   } gwr_write_t;
endpackage
`default_nettype wire

/* rtl/gwr_receiver.sv */
// Notes on behaviour
// - frame opens with start gap, opcode 10
// - next 32 bits form data word
// - last 4 bits give block address
// - program only on exact bit count
// - count field clocks between gaps, decode
// - count 16 to 31 decodes zero
// - counts outside 16-31 and 48-63 abort to read mode
// - read mode flag held high from power-up
// - ten blocks of 32 bits
`default_nettype none
module gwr_receiver #(
   parameter int BLOCKS = 10
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_field_clk,
   input  wire logic              i_gap,
   input  wire logic              i_frame_end,
   output logic                   o_read_mode,
   output logic                   o_prog_stb,
   output gwr_pkg::gwr_write_t    o_prog,
   output logic                   o_error
);
   import gwr_pkg::*;

   // field-clock domain: decode and framing, reset caught from system domain
   logic [1:0]             rst_sync;
   logic                   frst;
   logic [2:0]             gap_sync;
   logic                   gap_pulse;
   logic [6:0]             cnt;
   gwr_state_t             state;
   logic [5:0]             nbits;
   logic [FRAME_BITS-1:0] shreg;
   logic                   f_abort;
   logic                   f_done_tgl;
   logic                   f_err_tgl;
   logic [FRAME_BITS-1:0] f_frame;
   logic [5:0]             f_nbits;
   logic                   is_zero;
   logic                   is_one;
   logic                   in_frame;

   // field domain reset is released two field clocks after i_rst
   always_ff @(posedge i_field_clk) begin
      rst_sync <= {rst_sync[0], i_rst};
   end
   assign frst = rst_sync[1];

   always_ff @(posedge i_field_clk) begin
      if (frst) gap_sync <= 3'h0;
      else gap_sync <= {gap_sync[1:0], i_gap};
   end
   assign gap_pulse = gap_sync[1] & ~gap_sync[2];

   assign is_zero  = (cnt <= {1'b0, ZERO_MAX}) && (cnt >= {1'b0, ZERO_MIN});
   assign is_one   = (cnt <= {1'b0, ONE_MAX})  && (cnt >= {1'b0, ONE_MIN});
   assign in_frame = (state == GWR_RECV);

   always_ff @(posedge i_field_clk) begin
      // the gap cycle itself is the first counted field clock
      if (frst) cnt <= 7'h0;
      else if (gap_pulse) cnt <= 7'h1;
      else if (cnt != CNT_SAT) cnt <= cnt + 7'h1;
   end

   always_ff @(posedge i_field_clk) begin
      if (frst) begin
         state      <= GWR_READ;
         nbits      <= 6'h0;
         shreg      <= '0;
         f_done_tgl <= 1'b0;
         f_err_tgl  <= 1'b0;
         f_frame    <= '0;
         f_nbits    <= 6'h0;
      end else begin
         case (state)
            GWR_READ: begin
               if (gap_pulse) begin
                  state <= GWR_START;
               end
            end
            GWR_START: begin
               if (gap_pulse) begin
                  state <= GWR_RECV;
                  nbits <= 6'h0;
               end else if (cnt == CNT_SAT) begin
                  // lone start gap with no follow-up: fall back to read mode
                  state <= GWR_READ;
               end
            end
            default: begin
               if (gap_pulse) begin
                  if (is_zero || is_one) begin
                     shreg <= {shreg[FRAME_BITS-2:0], is_one};
                     nbits <= (nbits == 6'h3f) ? nbits : nbits + 6'h1;
                  end else begin
                     state     <= GWR_READ;
                     f_err_tgl <= ~f_err_tgl;
                  end
               end else if (cnt == CNT_SAT) begin
                  // field stays on after last bit: frame closes here
                  state      <= GWR_READ;
                  f_frame    <= shreg;
                  f_nbits    <= nbits;
                  f_done_tgl <= ~f_done_tgl;
               end
            end
         endcase
      end
   end
   assign f_abort = 1'b0;

   // system domain: toggle crossing and block programming
   logic [2:0]  done_sync;
   logic [2:0]  err_sync;
   logic        done_evt;
   logic        err_evt;
   logic        frame_ok;
   logic [1:0]  rx_op;
   logic [ADDR_BITS-1:0] rx_addr;
   logic [DATA_BITS-1:0] rx_data;
   logic [DATA_BITS-1:0] mem [BLOCKS];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         done_sync <= 3'h0;
         err_sync  <= 3'h0;
      end else begin
         done_sync <= {done_sync[1:0], f_done_tgl};
         err_sync  <= {err_sync[1:0], f_err_tgl};
      end
   end
   assign done_evt = done_sync[2] ^ done_sync[1];
   assign err_evt  = err_sync[2] ^ err_sync[1];

   // frame is stable from toggle until next frame, long past two clk edges
   assign rx_op    = f_frame[FRAME_BITS-1 -: OP_BITS];
   assign rx_data  = f_frame[ADDR_BITS +: DATA_BITS];
   assign rx_addr  = f_frame[ADDR_BITS-1:0];
   assign frame_ok = (f_nbits == FRAME_CNT_W) && (rx_op == WRITE_OPCODE)
                     && (rx_addr < ADDR_BITS'(BLOCKS));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prog_stb  <= 1'b0;
         o_prog      <= '0;
         o_error     <= 1'b0;
         o_read_mode <= 1'b1;
      end else begin
         o_prog_stb  <= done_evt && frame_ok;
         o_error     <= err_evt || (done_evt && !frame_ok);
         o_read_mode <= 1'b1;
         if (done_evt && frame_ok) begin
            o_prog.addr <= rx_addr;
            o_prog.data <= rx_data;
         end
      end
   end

   // block store; nothing in the design reads it back
   always_ff @(posedge i_clk) begin
      if (done_evt && frame_ok) mem[rx_addr] <= rx_data;
   end

   logic unused;
   assign unused = i_frame_end ^ f_abort ^ in_frame;

   a_count_sat: assert property (@(posedge i_field_clk) disable iff (frst)
      cnt <= CNT_SAT) else $error("interval counter past saturation");
   a_gap_pulse: assert property (@(posedge i_field_clk) disable iff (frst)
      gap_pulse |=> !gap_pulse) else $error("gap pulse longer than one cycle");
   a_count_restart: assert property (@(posedge i_field_clk) disable iff (frst)
      gap_pulse |=> cnt == 7'h1) else $error("counter not restarted by gap");
   a_bad_abort: assert property (@(posedge i_field_clk) disable iff (frst)
      (in_frame && gap_pulse && !is_zero && !is_one) |=> state == GWR_READ)
      else $error("bad interval did not abort");
   a_zero_shift: assert property (@(posedge i_field_clk) disable iff (frst)
      (in_frame && gap_pulse && is_zero) |=> shreg[0] == 1'b0)
      else $error("zero not shifted");
   a_one_shift: assert property (@(posedge i_field_clk) disable iff (frst)
      (in_frame && gap_pulse && is_one) |=> shreg[0] == 1'b1)
      else $error("one not shifted");
   a_prog_exact: assert property (@(posedge i_clk) disable iff (i_rst)
      o_prog_stb |-> $past(f_nbits) == FRAME_CNT_W)
      else $error("programmed with wrong bit count");
   a_prog_addr: assert property (@(posedge i_clk) disable iff (i_rst)
      o_prog_stb |-> o_prog.addr < ADDR_BITS'(BLOCKS))
      else $error("program address out of range");
   a_read_mode: assert property (@(posedge i_clk) disable iff (i_rst)
      o_read_mode) else $error("read mode dropped");

   // frame hand-over, start timeout and reporting across the crossing
   a_frame_close: assert property (@(posedge i_field_clk) disable iff (frst)
      (in_frame && !gap_pulse && cnt == CNT_SAT) |=> state == GWR_READ && $changed(f_done_tgl))
      else $error("frame not closed on missing gap");
   a_start_timeout: assert property (@(posedge i_field_clk) disable iff (frst)
      (state == GWR_START && !gap_pulse && cnt == CNT_SAT) |=> state == GWR_READ)
      else $error("start gap not timed out");
   a_prog_data: assert property (@(posedge i_clk) disable iff (i_rst)
      o_prog_stb |-> o_prog.data == $past(rx_data))
      else $error("programmed data differs from frame");
   a_bad_frame: assert property (@(posedge i_clk) disable iff (i_rst)
      (done_evt && !frame_ok) |=> o_error && !o_prog_stb)
      else $error("bad frame not reported");
   a_err_report: assert property (@(posedge i_clk) disable iff (i_rst)
      err_evt |=> o_error)
      else $error("bad interval not reported");

   c_prog: cover property (@(posedge i_clk) disable iff (i_rst) o_prog_stb);
   c_bad_frame: cover property (@(posedge i_clk) disable iff (i_rst) done_evt && !frame_ok);
   c_zero: cover property (@(posedge i_field_clk) disable iff (frst) in_frame && gap_pulse && is_zero);
   c_error: cover property (@(posedge i_clk) disable iff (i_rst) o_error);
   c_one: cover property (@(posedge i_field_clk) disable iff (frst) in_frame && gap_pulse && is_one);
endmodule
`default_nettype wire

/* verif/gwr_base_station.sv */
`default_nettype none
module gwr_base_station (
   input  wire logic i_field_clk,
   output logic      o_gap
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_gap = 1'b0;
   // one gap, then n field clocks until the next gap rises
   task automatic gap(input int n);
      @(negedge i_field_clk) o_gap = 1'b1;
      repeat (2) @(negedge i_field_clk);
      o_gap = 1'b0;
      repeat (n - 3) @(negedge i_field_clk);
   endtask
   // start gap, then one counted on-time per bit msb first, then a closing gap
   task automatic send(input logic [37:0] w, input int nb, t0, t1, bad_at, t_bad);
      gap(24);
      for (int i = 0; i < nb; i++) begin
         gap((i == bad_at) ? t_bad : (w[nb-1-i] ? t1 : t0));
      end
      gap(3);
   endtask
endmodule
`default_nettype wire

/* verif/gwr_receiver_tb_top.sv */
`default_nettype none
module gwr_receiver_tb_top;
   import gwr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic       i_clk, i_rst, i_field_clk, i_gap, i_frame_end;
   logic       o_read_mode, o_prog_stb, o_error;
   gwr_write_t o_prog, got, last;
   int         bad_count, cmp_count, n_stb, n_err;
   int         bad_t [4] = '{15, 32, 47, 84};
   gwr_receiver dut (.i_clk(i_clk), .i_rst(i_rst), .i_field_clk(i_field_clk),
      .i_gap(i_gap), .i_frame_end(i_frame_end), .o_read_mode(o_read_mode),
      .o_prog_stb(o_prog_stb), .o_prog(o_prog), .o_error(o_error));
   gwr_base_station bs (.i_field_clk(i_field_clk), .o_gap(i_gap));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      i_field_clk = 1'b0;
      #3;
      forever #7.5 i_field_clk = ~i_field_clk;
   end
   always @(negedge i_clk) begin
      if (o_prog_stb === 1'b1) begin
         n_stb++;
         got = o_prog;
      end
      if (o_error === 1'b1) n_err++;
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk_bit(input logic g, e, input string m);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic chk_prog(input gwr_write_t g, e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t write word %h expected %h", $time, g, e);
      end
   endtask
   task automatic frame(input logic [37:0] w, input int nb, t0, t1, bad_at, t_bad);
      n_stb = 0;
      n_err = 0;
      bs.send(w, nb, t0, t1, bad_at, t_bad);
      repeat (90) @(posedge i_field_clk);
   endtask
   task automatic test_write(input logic [3:0] a, input logic [31:0] d, input int t0, t1);
      frame({WRITE_OPCODE, d, a}, 38, t0, t1, -1, 0);
      last = '{addr: a, data: d};
      chk_bit(n_stb == 1 && n_err == 0, 1'b1, "good frame not written");
      chk_prog(got, last);
   endtask
   task automatic test_bad_interval(input int t);
      frame('0, 6, 20, 55, 5, t);
      chk_bit(n_stb == 0 && n_err > 0, 1'b1, "bad interval accepted");
   endtask
   task automatic test_bad_frame(input logic [37:0] w, input int nb);
      frame(w, nb, 20, 55, -1, 0);
      chk_bit(n_stb == 0 && n_err > 0, 1'b1, "bad frame accepted");
      chk_prog(o_prog, last);
   endtask
   initial begin
      i_rst = 1'b1;
      i_frame_end = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (7) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (10) @(posedge i_field_clk);
      chk_bit(o_prog_stb | o_error, 1'b0, "pulse after reset");
      chk_bit(o_read_mode, 1'b1, "read mode lost");
      test_write(4'h3, 32'ha5c3_0f96, 20, 55);
      test_write(4'h9, 32'h8000_0001, 16, 63);
      test_write(4'h0, 32'h7ffe_fffe, 31, 48);
      foreach (bad_t[i]) test_bad_interval(bad_t[i]);
      test_bad_frame({WRITE_OPCODE, 32'h1234_5678, 4'h2} >> 1, 37);
      test_bad_frame({2'h1, 32'h1234_5678, 4'h2}, 38);
      test_bad_frame({WRITE_OPCODE, 32'h1234_5678, 4'ha}, 38);
      chk_bit(o_read_mode, 1'b1, "read mode lost");
      summarize();
   end
   initial begin
      #900000;
      bad_count++;
      summarize();
   end
endmodule
`default_nettype wire
